// ===== hdl/ebp_pins.sv
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
// Functional notes
// - low sixteen address lines drive every external access, all spaces share them.
// - upper seven address lines carry address only for program space accesses.
// - address outputs float during bus hold or while output-off is low.
// - in host wide mode the low address lines are inputs for host addressing.
// - one shared sixteen-bit bidirectional data bus, bit fifteen most significant.
// - data outputs float when not writing, during reset or hold request.
// - data outputs float whenever output-off is low, access or not.
// - enabled keepers hold each undriven data pin at its last level.
// - keepers off after reset; software toggles them through bank_switch_control.
module ebp_pins (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // core access port
    input  wire logic        core_req,
    input  wire logic [1:0]  core_space,
    input  wire logic [22:0] core_addr,
    input  wire logic        core_we,
    input  wire logic [15:0] core_wdata,
    output logic             core_ack,
    output logic      [15:0] core_rdata,
    // device pins
    input  wire logic        reset_input_n,
    input  wire logic        hold_req_n,
    output logic             hold_ack_n,
    input  wire logic        output_off_n,
    input  wire logic        host_port_wide_mode,
    output logic      [22:0] addr_o,
    output logic             addr_hi_oe,
    output logic             addr_lo_oe,
    input  wire logic [15:0] addr_i,
    output logic      [15:0] host_addr,
    input  wire logic [15:0] data_i,
    output logic      [15:0] data_o,
    output logic             data_oe,
    output logic      [15:0] data_keep_o,
    output logic      [15:0] data_keep_oe
);
    typedef enum logic [1:0] {
        EBP_IDLE,
        EBP_ADDR,
        EBP_DATA,
        EBP_HOLD
    } ebp_state_e;

    ebp_state_e  state_d,  state_q;
    logic [1:0]  cnt_d,    cnt_q;
    logic [22:0] addr_d,   addr_q;
    logic [1:0]  space_d,  space_q;
    logic        we_d,     we_q;
    logic [15:0] wdata_d,  wdata_q;
    logic [15:0] rdata_d,  rdata_q;
    logic        ack_d,    ack_q;
    logic [15:0] host_d,   host_q;

    localparam logic [1:0] LAST_CNT = 2'(ebp_pkg::DATA_CYCLES - 1);

    // access sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        addr_d  = addr_q;
        space_d = space_q;
        we_d    = we_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        ack_d   = 1'b0;
        case (state_q)
            EBP_IDLE: begin
                if (!hold_req_n) begin
                    state_d = EBP_HOLD;
                end else if (core_req) begin
                    state_d = EBP_ADDR;
                    addr_d  = core_addr;
                    space_d = core_space;
                    we_d    = core_we;
                    wdata_d = core_wdata;
                end
            end
            EBP_ADDR: begin
                state_d = EBP_DATA;
                cnt_d   = 2'h0;
            end
            EBP_DATA: begin
                if (cnt_q == LAST_CNT) begin
                    if (!we_q) begin
                        rdata_d = data_i;
                    end
                    ack_d   = 1'b1;
                    state_d = EBP_IDLE;
                end else begin
                    cnt_d = cnt_q + 2'h1;
                end
            end
            EBP_HOLD: begin
                if (hold_req_n) begin
                    state_d = EBP_IDLE;
                end
            end
            default: begin
                state_d = EBP_IDLE;
            end
        endcase
        // reset pin aborts any access, no answer given
        if (!reset_input_n) begin
            state_d = EBP_IDLE;
            ack_d   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= EBP_IDLE;
            cnt_q   <= 2'h0;
            addr_q  <= 23'h000000;
            space_q <= 2'h0;
            we_q    <= 1'b0;
            wdata_q <= 16'h0000;
            rdata_q <= 16'h0000;
            ack_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            addr_q  <= addr_d;
            space_q <= space_d;
            we_q    <= we_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
        end
    end

    // host address capture, pins are inputs in this mode
    always_comb begin
        host_d = host_q;
        if (host_port_wide_mode) begin
            host_d = addr_i;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            host_q <= 16'h0000;
        end else begin
            host_q <= host_d;
        end
    end

    logic prog_sp;
    assign prog_sp = (space_q == 2'(ebp_pkg::EBP_SP_PROG));

    assign addr_o[15:0]  = addr_q[15:0];
    assign addr_o[22:16] = prog_sp ? addr_q[22:16] : 7'h00;
    assign addr_hi_oe    = (state_q != EBP_HOLD) && output_off_n;
    assign addr_lo_oe    = addr_hi_oe && !host_port_wide_mode;

    // drive only own write data phase
    assign data_oe    = (state_q == EBP_DATA) && we_q && output_off_n && reset_input_n && hold_req_n;
    assign data_o     = wdata_q;
    assign hold_ack_n = !(state_q == EBP_HOLD);
    assign core_ack   = ack_q;
    assign core_rdata = rdata_q;
    assign host_addr  = host_q;

    // register slave, one wait state, ack drops the cycle after
    logic        keep_en_d, keep_en_q;
    logic        wack_d,    wack_q;
    logic [31:0] wdat_d,    wdat_q;
    logic        wb_hit;
    logic [31:0] status_w;

    assign wb_hit = wb_cyc_i && wb_stb_i && !wack_q;

    always_comb begin
        status_w = 32'h00000000;
        status_w[ebp_pkg::ST_HOLD_BIT] = (state_q == EBP_HOLD);
        status_w[ebp_pkg::ST_OFF_BIT]  = !output_off_n;
        status_w[ebp_pkg::ST_HOST_BIT] = host_port_wide_mode;
        status_w[ebp_pkg::ST_BUSY_BIT] = (state_q == EBP_ADDR) || (state_q == EBP_DATA);
        status_w[ebp_pkg::ST_KEEP_BIT] = keep_en_q;
    end

    always_comb begin
        keep_en_d = keep_en_q;
        wack_d    = wb_hit;
        wdat_d    = wdat_q;
        if (wb_hit) begin
            wdat_d = 32'h00000000;
            case (wb_adr_i)
                ebp_pkg::BANK_CTRL_OFS: begin
                    wdat_d[ebp_pkg::KEEP_EN_BIT] = keep_en_q;
                end
                ebp_pkg::STATUS_OFS: begin
                    wdat_d = status_w;
                end
                default: begin
                    wdat_d = 32'h00000000;
                end
            endcase
        end
        // write lands on the ack edge
        if (wack_q && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == ebp_pkg::BANK_CTRL_OFS) begin
            keep_en_d = wb_dat_i[ebp_pkg::KEEP_EN_BIT];
        end
        if (!reset_input_n) begin
            keep_en_d = ebp_pkg::KEEP_EN_RST;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            keep_en_q <= ebp_pkg::KEEP_EN_RST;
            wack_q    <= 1'b0;
            wdat_q    <= 32'h00000000;
        end else begin
            keep_en_q <= keep_en_d;
            wack_q    <= wack_d;
            wdat_q    <= wdat_d;
        end
    end

    assign wb_ack_o = wack_q;
    assign wb_dat_o = wdat_q;

    ebp_keeper u_keeper (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .keep_en   (keep_en_q),
        .dev_drive (data_oe),
        .pad_level (data_i),
        .keep_o    (data_keep_o),
        .keep_oe   (data_keep_oe)
    );

    sequence s_acc_start;
        state_q == EBP_IDLE && core_req && hold_req_n && reset_input_n;
    endsequence

    sequence s_acc_run;
        reset_input_n [*3];
    endsequence

    chk_low_addr: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_q == EBP_ADDR) |-> addr_o[15:0] == $past(core_addr[15:0]))
        else $error("low address lines do not carry access address");

    chk_hi_addr_prog: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_q == EBP_DATA && !prog_sp) |-> addr_o[22:16] == 7'h00)
        else $error("upper address used outside program space");

    chk_addr_float: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_q == EBP_HOLD || !output_off_n) |-> !addr_hi_oe && !addr_lo_oe)
        else $error("address driven during hold or output-off");

    chk_host_lo_in: assert property (@(posedge clk_sys) disable iff (!arst_n)
        host_port_wide_mode |=> host_addr == $past(addr_i) && (!addr_lo_oe || !host_port_wide_mode))
        else $error("host mode address handling wrong");

    chk_access_ack: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_acc_start ##1 s_acc_run |=> core_ack ##1 !core_ack)
        else $error("access not answered in four cycles");

    chk_data_float: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!we_q || !reset_input_n || !hold_req_n) |-> !data_oe)
        else $error("data driven while not writing");

    chk_off_float: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !output_off_n |-> !data_oe)
        else $error("data driven while output-off low");

    chk_keeper_reset: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !reset_input_n |=> !keep_en_q && data_keep_oe == 16'h0000)
        else $error("keepers enabled after reset");

    chk_write_phase: assert property (@(posedge clk_sys) disable iff (!arst_n)
        data_oe |-> state_q == EBP_DATA && we_q && $past(state_q) != EBP_IDLE)
        else $error("data driven outside write data phase");
endmodule : ebp_pins

// ===== hdl/ebp_pkg.sv
package ebp_pkg;
    // timing
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          DATA_PHASE_NS  = 8;
    localparam int          DATA_CYCLES    = (DATA_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // pin widths
    localparam int          ADDR_W         = 23;
    localparam int          ADDR_LO_W      = 16;
    localparam int          DATA_W         = 16;

    // register map, byte addresses
    localparam logic [7:0]  BANK_CTRL_OFS  = 8'h00;
    localparam logic [7:0]  STATUS_OFS     = 8'h04;

    // bank_switch_control fields
    localparam int          KEEP_EN_BIT    = 0;
    localparam logic        KEEP_EN_RST    = 1'b0;

    // status fields
    localparam int          ST_HOLD_BIT    = 0;
    localparam int          ST_OFF_BIT     = 1;
    localparam int          ST_HOST_BIT    = 2;
    localparam int          ST_BUSY_BIT    = 3;
    localparam int          ST_KEEP_BIT    = 4;

    // access spaces
    typedef enum logic [1:0] {
        EBP_SP_PROG,
        EBP_SP_DATA,
        EBP_SP_IO
    } ebp_space_e;
endpackage : ebp_pkg

// ===== hdl/ebp_keeper.sv
`timescale 1ns/1ns
module ebp_keeper (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        keep_en,
    input  wire logic        dev_drive,
    input  wire logic [15:0] pad_level,
    output logic      [15:0] keep_o,
    output logic      [15:0] keep_oe
);
    logic [15:0] last_d;
    logic [15:0] last_q;

    // per pin: follow the resolved wire, push it back weakly when nobody drives
    for (genvar i = 0; i < 16; i++) begin : g_bit
        always_comb begin
            last_d[i] = pad_level[i];
        end
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                last_q[i] <= 1'b0;
            end else begin
                last_q[i] <= last_d[i];
            end
        end
        assign keep_o[i]  = last_q[i];
        assign keep_oe[i] = keep_en && !dev_drive;
    end

    chk_keep_level: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (keep_oe != 16'h0000) |-> keep_o == $past(pad_level))
        else $error("keeper does not hold last level");
endmodule : ebp_keeper

// ===== dv/ebp_ext_mem.sv
`timescale 1ns/1ns
// far-side memory and I/O, keyed by the full pin address
module ebp_ext_mem (
    input  wire logic        clk_sys,
    input  wire logic [22:0] addr_o,
    input  wire logic        data_oe,
    input  wire logic [15:0] data_o,
    input  wire logic        rd_en,
    output logic      [15:0] mem_q,
    output logic             mem_oe
);
    logic [15:0] store [int];
    // take writes only from driven pins
    always @(posedge clk_sys) begin
        if (data_oe === 1'b1) begin
            store[int'(addr_o)] = data_o;
        end
    end
    // never fights the device drivers
    assign mem_oe = rd_en && (data_oe !== 1'b1);
    always_comb begin
        mem_q = store.exists(int'(addr_o)) ? store[int'(addr_o)] : 16'h0000;
    end
endmodule : ebp_ext_mem

// ===== dv/test_ebp_pins.sv
`timescale 1ns/1ns
module test_ebp_pins;
    logic        clk_sys = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf, sel_use = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'hba05, rv;
    logic        core_req = 1'b0, core_we = 1'b0, rd_en = 1'b0, reset_input_n = 1'b1, hold_req_n = 1'b1;
    logic        output_off_n = 1'b1, host_port_wide_mode = 1'b0, wb_ack_o, core_ack, hold_ack_n;
    logic        addr_hi_oe, addr_lo_oe, data_oe, mem_oe;
    logic [1:0]  core_space = 2'h0;
    logic [22:0] core_addr = 23'h0, addr_o;
    logic [15:0] core_wdata = 16'h0, host_a = 16'h0, flt = 16'h0, core_rdata, host_addr, data_o, data_keep_o;
    logic [15:0] data_keep_oe, mem_q, data_pin, addr_pin, rd;
    logic [15:0] exp_mem [int];
    int          n_fail = 0, checks_done = 0;

    assign addr_pin = addr_lo_oe ? addr_o[15:0] : host_a;
    // released pins show the inverse of their last level
    assign data_pin = data_oe ? data_o : mem_oe ? mem_q : data_keep_oe[0] ? data_keep_o : flt;
    always @(posedge clk_sys) flt <= ~data_pin;
    initial forever #2 clk_sys = ~clk_sys;

    ebp_pins dut (
        .clk_sys, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .core_req, .core_space, .core_addr, .core_we, .core_wdata, .core_ack, .core_rdata,
        .reset_input_n, .hold_req_n, .hold_ack_n, .output_off_n, .host_port_wide_mode, .addr_o, .addr_hi_oe,
        .addr_lo_oe, .addr_i(addr_pin), .host_addr, .data_i(data_pin), .data_o, .data_oe, .data_keep_o,
        .data_keep_oe
    );
    ebp_ext_mem mem (.clk_sys, .addr_o, .data_oe, .data_o, .rd_en, .mem_q, .mem_oe);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel_use;
        wb_dat_i <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        chk("wb_ack", 32'h1, 32'(wb_ack_o));
        @(posedge clk_sys);
    endtask : wb

    // request is a one-cycle pulse so the ack edge cannot take a second access
    task automatic core_xfer(input logic [1:0] sp, input logic [22:0] a, input logic we, input logic [15:0] d);
        int n;
        n = 0;
        core_req <= 1'b1;
        core_space <= sp;
        core_addr <= a;
        core_we <= we;
        core_wdata <= d;
        rd_en <= !we;
        @(posedge clk_sys);
        core_req <= 1'b0;
        do begin
            @(posedge clk_sys);
            n++;
            if (data_oe === 1'b1) chk("data_o", 32'(d), 32'(data_o));
            if (!output_off_n) chk("oe off", 32'h0, 32'({addr_hi_oe, addr_lo_oe, data_oe}));
            if (!we) chk("oe read", 32'h0, 32'(data_oe));
        end while (core_ack !== 1'b1 && n < 20);
        rd_en <= 1'b0;
        rd = core_rdata;
        chk("core_ack", 32'h1, 32'(core_ack));
        chk("addr_o", 32'((sp == 2'd0) ? a : {7'h00, a[15:0]}), 32'(addr_o));
        @(posedge clk_sys);
    endtask : core_xfer

    initial begin
        #40000;
        n_fail++;
        end_of_test();
    end

    initial begin
        logic [22:0] a;
        logic [15:0] d;
        int          k;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        wb(1'b0, 8'h00, 32'h0);
        chk("bank ctrl", 32'h0, rv);
        chk("keep oe", 32'h0, 32'(data_keep_oe));
        chk("data_oe", 32'h0, 32'(data_oe));
        $display("done reset");
        for (int i = 0; i < 9; i++) begin
            rv = rnd();
            a = rv[22:0];
            d = rv[31:16] ^ rv[15:0];
            k = int'((i % 3 == 0) ? a : {7'h00, a[15:0]});
            output_off_n <= (i != 7);
            core_xfer(2'(i % 3), a, 1'b1, d);
            if (i != 7) exp_mem[k] = d;
            output_off_n <= 1'b1;
            core_xfer(2'(i % 3), a, 1'b0, 16'h0);
            chk("core_rdata", 32'(exp_mem.exists(k) ? exp_mem[k] : 16'h0000), 32'(rd));
        end
        $display("done access");
        hold_req_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("hold pins", 32'h0, 32'({hold_ack_n, addr_hi_oe, addr_lo_oe, data_oe}));
        wb(1'b0, 8'h04, 32'h0);
        chk("status", 32'h1, rv & 32'h1f);
        hold_req_n <= 1'b1;
        host_port_wide_mode <= 1'b1;
        host_a <= 16'h5a3c;
        repeat (3) @(posedge clk_sys);
        chk("host lo oe", 32'h0, 32'(addr_lo_oe));
        chk("host_addr", 32'h5a3c, 32'(host_addr));
        host_port_wide_mode <= 1'b0;
        $display("done hold host");
        wb(1'b1, 8'h00, 32'h1);
        sel_use = 4'he;
        wb(1'b1, 8'h00, 32'h0);
        sel_use = 4'hf;
        wb(1'b0, 8'h00, 32'h0);
        chk("bank ctrl", 32'h1, rv);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rv);
        core_xfer(2'd1, 23'h1234, 1'b1, 16'hc3a5);
        repeat (3) @(posedge clk_sys);
        chk("keep oe", 32'hffff, 32'(data_keep_oe));
        chk("keep level", 32'hc3a5, 32'(data_keep_o));
        // reset pin in the last cycle of a write data phase
        core_wdata <= 16'h3c5a;
        core_req <= 1'b1;
        @(posedge clk_sys);
        core_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_input_n <= 1'b0;
        @(posedge clk_sys);
        chk("data_oe", 32'h0, 32'(data_oe));
        reset_input_n <= 1'b1;
        @(posedge clk_sys);
        chk("abort ack", 32'h0, 32'(core_ack));
        wb(1'b0, 8'h00, 32'h0);
        chk("bank ctrl", 32'h0, rv);
        chk("keep oe", 32'h0, 32'(data_keep_oe));
        $display("done keeper");
        end_of_test();
    end
endmodule : test_ebp_pins
